//--- hdl/evt_defines.svh
// Purpose: constants of the extended VLAN rule tagger
// Assumes: included by bare name from the modules only, not from the package
// Notes: default entries are laid out as evt_entry_t, msb first
`ifndef EVT_DEFINES_SVH
`define EVT_DEFINES_SVH

// ----------------------------------------------------------------
// filter and treatment codes
// ----------------------------------------------------------------
`define EVT_PRIO_NONE 4'hF
`define EVT_PRIO_DFLT 4'hE
`define EVT_PRIO_ANY 4'h8
`define EVT_PRIO_MAXV 4'h7
`define EVT_VID_ANY 13'h1000
`define EVT_VID_MAXV 13'h0FFE
`define EVT_TPD_NONE 3'h0
`define EVT_TPD_8100 3'h4
`define EVT_TPD_SPEC 3'h5
`define EVT_TPD_DE0 3'h6
`define EVT_TPD_DE1 3'h7
`define EVT_TPID_STD 16'h8100
`define EVT_RM_RSVD 2'h3

// ----------------------------------------------------------------
// ethertype filter
// ----------------------------------------------------------------
`define EVT_ET_NONE 4'h0
`define EVT_ET_IPOE 4'h1
`define EVT_ET_PPPOE 4'h2
`define EVT_ET_ARP 4'h3
`define EVT_ETV_IPOE 16'h0800
`define EVT_ETV_PPPD 16'h8863
`define EVT_ETV_PPPS 16'h8864
`define EVT_ETV_ARP 16'h0806

// ----------------------------------------------------------------
// attribute selectors and reset values
// ----------------------------------------------------------------
`define EVT_SEL_INST 3'h0
`define EVT_SEL_ASSOC 3'h1
`define EVT_SEL_CAP 3'h2
`define EVT_SEL_FTPID 3'h3
`define EVT_SEL_TTPID 3'h4
`define EVT_SEL_MODE 3'h5
`define EVT_SEL_BYTES 3'h6
`define EVT_MODE_INV 8'h00
`define EVT_MODE_PASS 8'h01
`define EVT_RST_TPID 16'h88A8
`define EVT_RST_ASSOC 8'h00
`define EVT_RST_MODE 8'h00

// ----------------------------------------------------------------
// default entries in sorted key order
// ----------------------------------------------------------------
`define EVT_DFLT_DBL 128'hE0000000_E0000000_000F0000_F0000000
`define EVT_DFLT_SGL 128'hF0000000_E0000000_000F0000_F0000000
`define EVT_DFLT_UNT 128'hF0000000_F0000000_000F0000_F0000000
`define EVT_DEL_MARK 64'hFFFFFFFF_FFFFFFFF

`endif

//--- hdl/evt_hdr_if.sv
// Purpose: carries the frame header from the top to the rule matchers
// Assumes: one driver, many sinks
// Notes: no clocking, plain signals
interface evt_hdr_if;
    import evt_pkg::*;
    evt_hdr_t hdr;
    modport drv (output hdr);
    modport snk (input hdr);
endinterface : evt_hdr_if

//--- hdl/evt_pkg.sv
// Purpose: types shared by the rule tagger modules
// Assumes: nothing
// Notes: a single-tagged frame carries its tag in the inner slot
package evt_pkg;

    typedef struct packed {
        logic [15:0] tpid;
        logic [2:0] pcp;
        logic de;
        logic [11:0] vid;
    } evt_tag_t;

    typedef struct packed {
        logic [1:0] ntags;
        evt_tag_t outer;
        evt_tag_t inner;
        logic [15:0] etype;
    } evt_hdr_t;

    typedef struct packed {
        logic [3:0] fo_prio;
        logic [12:0] fo_vid;
        logic [2:0] fo_tpid;
        logic [11:0] pad1;
        logic [3:0] fi_prio;
        logic [12:0] fi_vid;
        logic [2:0] fi_tpid;
        logic [7:0] pad2;
        logic [3:0] f_etype;
        logic [1:0] t_rm;
        logic [9:0] pad3;
        logic [3:0] to_prio;
        logic [12:0] to_vid;
        logic [2:0] to_tpid;
        logic [3:0] ti_prio;
        logic [12:0] ti_vid;
        logic [2:0] ti_tpid;
        logic [11:0] pad4;
    } evt_entry_t;

endpackage : evt_pkg

//--- hdl/evt_rule_match.sv
// Purpose: compares one rule entry against a frame header, both directions
// Assumes: header tags right aligned, inner slot filled first
// Notes: purely combinational
`include "evt_defines.svh"
module evt_rule_match import evt_pkg::*; (
    // entry under test
    input wire evt_entry_t ent,
    input wire logic ent_valid,
    input wire logic [15:0] ftpid,
    // frame header
    evt_hdr_if.snk hif,
    // results
    output logic up_hit,
    output logic dn_hit,
    output logic is_dflt
);

    function automatic logic tag_ok(input logic [3:0] p, input logic [12:0] v, input logic [2:0] t,
                                    input evt_tag_t g, input logic [15:0] sp);
        logic tp;
        tp = 1'b0;
        unique case (t)
            `EVT_TPD_NONE: tp = 1'b1;
            `EVT_TPD_8100: tp = (g.tpid == `EVT_TPID_STD);
            `EVT_TPD_SPEC: tp = (g.tpid == sp);
            `EVT_TPD_DE0: tp = (g.tpid == sp) && !g.de;
            `EVT_TPD_DE1: tp = (g.tpid == sp) && g.de;
            default: tp = 1'b0;
        endcase
        // a default priority code ignores every other field of that tag
        return (p == `EVT_PRIO_DFLT) || (tp && (p > `EVT_PRIO_MAXV || g.pcp == p[2:0])
               && (v == `EVT_VID_ANY || v == {1'b0, g.vid}));
    endfunction : tag_ok

    function automatic logic add_ok(input logic [3:0] p, input logic [12:0] v, input evt_tag_t g);
        return (p > `EVT_PRIO_MAXV || g.pcp == p[2:0]) && (v > `EVT_VID_MAXV || v == {1'b0, g.vid});
    endfunction : add_ok

    logic [1:0] cat;
    logic [1:0] added;
    logic et_ok;
    evt_tag_t rx_top;

    always_comb begin
        // category from the priority filters
        if (ent.fo_prio != `EVT_PRIO_NONE) begin // see RULE_04
            cat = 2'd2;
        end else if (ent.fi_prio != `EVT_PRIO_NONE) begin
            cat = 2'd1;
        end else begin
            cat = 2'd0;
        end
        if (ent.ti_prio == `EVT_PRIO_NONE) begin // see RULE_06
            added = 2'd0;
        end else if (ent.to_prio == `EVT_PRIO_NONE) begin
            added = 2'd1;
        end else begin
            added = 2'd2;
        end
        unique case (ent.f_etype)
            `EVT_ET_NONE: et_ok = 1'b1;
            `EVT_ET_IPOE: et_ok = (hif.hdr.etype == `EVT_ETV_IPOE);
            `EVT_ET_PPPOE: et_ok = (hif.hdr.etype == `EVT_ETV_PPPD) || (hif.hdr.etype == `EVT_ETV_PPPS);
            `EVT_ET_ARP: et_ok = (hif.hdr.etype == `EVT_ETV_ARP);
            default: et_ok = 1'b0;
        endcase
        rx_top = (hif.hdr.ntags == 2'd2) ? hif.hdr.outer : hif.hdr.inner;
    end

    // tag count must equal the rule category before any field is looked at
    assign up_hit = ent_valid && (hif.hdr.ntags == cat) && et_ok && (ent.t_rm != `EVT_RM_RSVD) // see RULE_03
                    && (cat == 2'd0 || tag_ok(ent.fi_prio, ent.fi_vid, ent.fi_tpid, hif.hdr.inner, ftpid)) // see RULE_20
                    && (cat != 2'd2 || tag_ok(ent.fo_prio, ent.fo_vid, ent.fo_tpid, hif.hdr.outer, ftpid)); // see RULE_21

    // a received downstream frame must carry the tags this rule adds upstream
    assign dn_hit = ent_valid && (hif.hdr.ntags >= added) && (ent.t_rm != `EVT_RM_RSVD)
                    && ((hif.hdr.ntags - added + ent.t_rm) == {1'b0, cat}) // see RULE_14
                    && (added != 2'd1 || add_ok(ent.ti_prio, ent.ti_vid, rx_top))
                    && (added != 2'd2 || (add_ok(ent.to_prio, ent.to_vid, hif.hdr.outer)
                                          && add_ok(ent.ti_prio, ent.ti_vid, hif.hdr.inner)));

    assign is_dflt = ent_valid && (ent[127:64] == `EVT_DFLT_DBL >> 64 || ent[127:64] == `EVT_DFLT_SGL >> 64
                                   || ent[127:64] == `EVT_DFLT_UNT >> 64); // see RULE_11

endmodule : evt_rule_match

//--- hdl/evt_tag_build.sv
// Purpose: applies one rule's treatment upstream or its inverse downstream
// Assumes: header tags right aligned, outer slot used only with two tags
// Notes: pushing onto a double-tagged header overwrites the outer tag
`include "evt_defines.svh"
module evt_tag_build import evt_pkg::*; (
    // rule and direction
    input wire evt_entry_t ent,
    input wire logic inverse,
    input wire logic [15:0] ftpid,
    input wire logic [15:0] ttpid,
    // frame
    input wire evt_hdr_t rx,
    output evt_hdr_t tx
);

    function automatic evt_hdr_t pop(input evt_hdr_t h, input logic [1:0] k);
        evt_hdr_t r;
        r = h;
        // removal always strips from the outer side
        r.ntags = (k >= h.ntags) ? 2'd0 : h.ntags - k; // see RULE_22
        return r;
    endfunction : pop

    function automatic evt_hdr_t push(input evt_hdr_t h, input evt_tag_t g);
        evt_hdr_t r;
        r = h;
        if (h.ntags == 2'd0) begin
            r.inner = g;
            r.ntags = 2'd1;
        end else begin
            r.outer = g;
            r.ntags = 2'd2;
        end
        return r;
    endfunction : push

    function automatic evt_tag_t mk_add(input logic [3:0] p, input logic [12:0] v, input logic [2:0] t);
        evt_tag_t g;
        g.pcp = (p == `EVT_PRIO_ANY) ? rx.inner.pcp : p[2:0];
        g.vid = (v == `EVT_VID_ANY) ? rx.inner.vid : v[11:0];
        g.tpid = t[2] ? ttpid : `EVT_TPID_STD; // see RULE_17
        g.de = (t == `EVT_TPD_DE1) || (t != `EVT_TPD_DE0 && rx.inner.de);
        return g;
    endfunction : mk_add

    // restored tags take the lowest value wherever the filter did not care
    function automatic evt_tag_t mk_rst(input logic [3:0] p, input logic [12:0] v, input logic [2:0] t);
        evt_tag_t g;
        g.pcp = (p > `EVT_PRIO_MAXV) ? 3'h0 : p[2:0]; // see RULE_15
        g.vid = (v > `EVT_VID_MAXV) ? 12'h000 : v[11:0];
        g.tpid = t[2] ? ftpid : `EVT_TPID_STD;
        g.de = (t == `EVT_TPD_DE1);
        return g;
    endfunction : mk_rst

    logic dbl;
    logic [1:0] added;
    evt_hdr_t h;

    always_comb begin
        dbl = (ent.fo_prio != `EVT_PRIO_NONE);
        if (ent.ti_prio == `EVT_PRIO_NONE) begin
            added = 2'd0;
        end else if (ent.to_prio == `EVT_PRIO_NONE) begin
            added = 2'd1;
        end else begin
            added = 2'd2;
        end
        if (!inverse) begin
            // modify is a removal followed by an addition
            h = pop(rx, ent.t_rm); // see RULE_05
            if (added != 2'd0) begin
                h = push(h, mk_add(ent.ti_prio, ent.ti_vid, ent.ti_tpid)); // see RULE_06
            end
            if (added == 2'd2) begin
                h = push(h, mk_add(ent.to_prio, ent.to_vid, ent.to_tpid));
            end
        end else begin
            h = pop(rx, added); // see RULE_14
            if (dbl && ent.t_rm == 2'd2) begin
                h = push(h, mk_rst(ent.fi_prio, ent.fi_vid, ent.fi_tpid));
            end
            if (ent.t_rm != 2'd0) begin
                h = dbl ? push(h, mk_rst(ent.fo_prio, ent.fo_vid, ent.fo_tpid))
                        : push(h, mk_rst(ent.fi_prio, ent.fi_vid, ent.fi_tpid));
            end
        end
        tx = h;
    end

endmodule : evt_tag_build

//--- hdl/evt_tagger.sv
// Purpose: ordered VLAN tagging rule table with upstream and inverse treatment
// Assumes: one frame header per valid cycle, one table write per tbl_wr pulse
// Notes: all results appear one cycle after the request
`include "evt_defines.svh"

// Summary of operation
// RULE_01: each upstream frame takes the first matching entry in ascending order.
// RULE_02: an entry holds seven filter fields followed by seven treatment fields.
// RULE_03: a rule only matches frames whose tag count equals its category.
// RULE_04: category comes from the two filter priorities and the value 15.
// RULE_05: treatment removes up to two tags then adds up to two.
// RULE_06: one added tag uses inner treatment fields; outer only when adding two.
// RULE_07: entries are keyed and sorted by their first eight bytes.
// RULE_08: a write whose last eight bytes are all FF deletes that key.
// RULE_09: every write adds, modifies or deletes exactly one entry; a missing-key delete or full-table insert changes none.
// RULE_10: three normal forwarding defaults are preloaded when the table is created.
// RULE_11: defaults apply only when no other rule of that category matches.
// RULE_12: defaults filter 15/15, 15/14, 14/14, remove none, add none.
// RULE_13: the manager writes zero into every don't-care field.
// RULE_14: mode 0 applies the inverse downstream, earliest rule wins on ties.
// RULE_15: inverse puts the lowest value into fields the filter ignored.
// RULE_16: mode 1 passes downstream frames untouched; other modes reserved.
// RULE_17: separate writable special TPIDs for filter side and tagging side.
// RULE_18: the table capacity is reported as a read-only 16-bit value.
// RULE_19: each entry is sixteen bytes; table length reads as sixteen times count.
// RULE_20: outer priority filter 0-7 match, 8 any, 14 default, 15 single.
// RULE_21: tpid filter codes 000, 100, 101, 110, 111 select the tag check.
// RULE_22: tags to remove is 0, 1 or 2, outer first; 3 reserved.
// RULE_23: an existing key is replaced in place, a new key inserted sorted.
// RULE_24: a write beyond the capacity is refused and the table kept.
module evt_tagger import evt_pkg::*; #(
    parameter int N_ENT = 16,
    parameter logic [15:0] INST_ID = 16'h0001 // arbitrary value
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // attribute access
    input wire logic attr_wr,
    input wire logic [2:0] attr_sel,
    input wire logic [15:0] attr_wdata,
    output logic [15:0] attr_rdata,
    // rule table access
    input wire logic tbl_wr,
    input wire logic [127:0] tbl_wdata,
    output logic tbl_ack,
    output logic tbl_err,
    input wire logic [$clog2(N_ENT)-1:0] tbl_rd_idx,
    output logic [127:0] tbl_rd_data,
    output logic [$clog2(N_ENT+1)-1:0] tbl_count,
    // frame header in
    input wire logic frm_valid,
    input wire logic frm_dir,
    input wire evt_hdr_t frm_hdr,
    // frame header out
    output logic res_valid,
    output logic res_hit,
    output logic [$clog2(N_ENT)-1:0] res_idx,
    output evt_hdr_t res_hdr
);

    localparam int IW = $clog2(N_ENT);
    localparam int CW = $clog2(N_ENT + 1);
    localparam logic [CW-1:0] CAP = CW'(N_ENT);

    typedef struct packed {
        logic [N_ENT-1:0][127:0] ent;
        logic [CW-1:0] cnt;
        logic [7:0] assoc;
        logic [15:0] ftpid;
        logic [15:0] ttpid;
        logic [7:0] mode;
        logic [15:0] attr_rdata;
        logic [127:0] rd_data;
        logic ack;
        logic err;
        logic res_valid;
        logic res_hit;
        logic [IW-1:0] res_idx;
        evt_hdr_t res_hdr;
    } evt_state_t;

    evt_state_t st_r;
    evt_state_t st_nxt;

    // ----------------------------------------------------------------
    // per-entry matching
    // ----------------------------------------------------------------
    evt_hdr_if hif ();
    assign hif.hdr = frm_hdr;

    logic [N_ENT-1:0] up_hit;
    logic [N_ENT-1:0] dn_hit;
    logic [N_ENT-1:0] dflt;
    logic [N_ENT-1:0] ent_vld;

    genvar g;
    generate
        for (g = 0; g < N_ENT; g++) begin : g_ent
            assign ent_vld[g] = (CW'(g) < st_r.cnt);
            evt_rule_match u_match (
                .ent(evt_entry_t'(st_r.ent[g])),
                .ent_valid(ent_vld[g]),
                .ftpid(st_r.ftpid),
                .hif(hif),
                .up_hit(up_hit[g]),
                .dn_hit(dn_hit[g]),
                .is_dflt(dflt[g])
            );
        end
    endgenerate

    // lowest index wins; defaults are tried only when nothing else hits
    function automatic logic [IW:0] pick(input logic [N_ENT-1:0] hits, input logic [N_ENT-1:0] df);
        logic [IW:0] r;
        r = '0;
        for (int i = N_ENT - 1; i >= 0; i--) begin
            if (hits[i] && df[i]) begin
                r = {1'b1, IW'(i)};
            end
        end
        for (int i = N_ENT - 1; i >= 0; i--) begin
            if (hits[i] && !df[i]) begin
                r = {1'b1, IW'(i)};
            end
        end
        return r;
    endfunction : pick

    logic [N_ENT-1:0] hits;
    logic [IW:0] sel;
    evt_hdr_t built;

    assign hits = frm_dir ? dn_hit : up_hit;
    assign sel = pick(hits, dflt); // see RULE_01 see RULE_11

    evt_tag_build u_build (
        .ent(evt_entry_t'(st_r.ent[sel[IW-1:0]])),
        .inverse(frm_dir),
        .ftpid(st_r.ftpid),
        .ttpid(st_r.ttpid),
        .rx(frm_hdr),
        .tx(built)
    );

    // ----------------------------------------------------------------
    // table write decode
    // ----------------------------------------------------------------
    logic [63:0] wkey;
    logic wdel;
    logic whit;
    logic [IW-1:0] hidx;
    logic [CW-1:0] lt_cnt;
    logic [IW-1:0] pos;
    logic do_tx;

    always_comb begin
        wkey = tbl_wdata[127:64]; // see RULE_07
        wdel = (tbl_wdata[63:0] == `EVT_DEL_MARK); // see RULE_08
        whit = 1'b0;
        hidx = '0;
        lt_cnt = '0;
        for (int i = 0; i < N_ENT; i++) begin
            if (ent_vld[i]) begin
                if (st_r.ent[i][127:64] < wkey) begin
                    lt_cnt = lt_cnt + 1'b1;
                end
                if (st_r.ent[i][127:64] == wkey) begin
                    whit = 1'b1;
                    hidx = IW'(i);
                end
            end
        end
        pos = lt_cnt[IW-1:0];
        do_tx = sel[IW] && (!frm_dir || st_r.mode == `EVT_MODE_INV); // see RULE_16
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = 1'b0;
        st_nxt.err = 1'b0;
        st_nxt.res_valid = 1'b0;
        if (attr_wr) begin
            // identifier, capacity and length are read-only and ignore writes
            case (attr_sel)
                `EVT_SEL_ASSOC: st_nxt.assoc = attr_wdata[7:0];
                `EVT_SEL_FTPID: st_nxt.ftpid = attr_wdata; // see RULE_17
                `EVT_SEL_TTPID: st_nxt.ttpid = attr_wdata;
                `EVT_SEL_MODE: st_nxt.mode = attr_wdata[7:0];
                default: st_nxt.mode = st_r.mode;
            endcase
        end
        // an accepted write adds, replaces or deletes exactly one entry; a refused write changes none
        if (tbl_wr) begin // see RULE_09
            st_nxt.ack = 1'b1;
            if (wdel) begin
                if (whit) begin
                    for (int i = 0; i < N_ENT - 1; i++) begin
                        if (IW'(i) >= hidx) begin
                            st_nxt.ent[i] = st_r.ent[i+1];
                        end
                    end
                    st_nxt.ent[N_ENT-1] = '0;
                    st_nxt.cnt = st_r.cnt - 1'b1;
                end else begin
                    st_nxt.err = 1'b1;
                end
            end else if (whit) begin
                st_nxt.ent[hidx] = tbl_wdata; // see RULE_23
            end else if (st_r.cnt == CAP) begin
                st_nxt.err = 1'b1; // see RULE_24
            end else begin
                // shift the tail up to keep the table sorted on its key
                for (int i = 1; i < N_ENT; i++) begin
                    if (IW'(i) > pos) begin
                        st_nxt.ent[i] = st_r.ent[i-1];
                    end
                end
                st_nxt.ent[pos] = tbl_wdata; // see RULE_02
                st_nxt.cnt = st_r.cnt + 1'b1;
            end
        end
        if (frm_valid) begin
            st_nxt.res_valid = 1'b1;
            st_nxt.res_hit = do_tx;
            st_nxt.res_idx = sel[IW-1:0];
            st_nxt.res_hdr = do_tx ? built : frm_hdr; // see RULE_05 see RULE_14
        end
        unique case (attr_sel)
            `EVT_SEL_INST: st_nxt.attr_rdata = INST_ID;
            `EVT_SEL_ASSOC: st_nxt.attr_rdata = {8'h00, st_r.assoc};
            `EVT_SEL_CAP: st_nxt.attr_rdata = 16'(N_ENT); // see RULE_18
            `EVT_SEL_FTPID: st_nxt.attr_rdata = st_r.ftpid;
            `EVT_SEL_TTPID: st_nxt.attr_rdata = st_r.ttpid;
            `EVT_SEL_MODE: st_nxt.attr_rdata = {8'h00, st_r.mode};
            `EVT_SEL_BYTES: st_nxt.attr_rdata = 16'({st_r.cnt, 4'h0}); // see RULE_19
            default: st_nxt.attr_rdata = 16'h0000;
        endcase
        st_nxt.rd_data = ent_vld[tbl_rd_idx] ? st_r.ent[tbl_rd_idx] : 128'h0;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
            // reset stands for table creation: normal forwarding defaults
            st_r.ent[0] <= `EVT_DFLT_DBL; // see RULE_10 see RULE_12
            st_r.ent[1] <= `EVT_DFLT_SGL;
            st_r.ent[2] <= `EVT_DFLT_UNT;
            st_r.cnt <= CW'(3);
            st_r.assoc <= `EVT_RST_ASSOC;
            st_r.ftpid <= `EVT_RST_TPID;
            st_r.ttpid <= `EVT_RST_TPID;
            st_r.mode <= `EVT_RST_MODE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign attr_rdata = st_r.attr_rdata;
    assign tbl_ack = st_r.ack;
    assign tbl_err = st_r.err;
    assign tbl_rd_data = st_r.rd_data;
    assign tbl_count = st_r.cnt;
    assign res_valid = st_r.res_valid;
    assign res_hit = st_r.res_hit;
    assign res_idx = st_r.res_idx;
    assign res_hdr = st_r.res_hdr;

endmodule : evt_tagger

//--- tb/evt_assertions.sv
// Purpose: port checks of the rule tagger
// Assumes: bound into evt_tagger, one clock
// Notes: every answer is fixed at one cycle
module evt_assertions import evt_pkg::*; #(
    parameter int N_ENT = 16
) (
    // watched ports
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] attr_sel,
    input wire logic [15:0] attr_rdata,
    input wire logic tbl_wr,
    input wire logic [127:0] tbl_wdata,
    input wire logic tbl_ack,
    input wire logic tbl_err,
    input wire logic [$clog2(N_ENT+1)-1:0] tbl_count,
    input wire logic frm_valid,
    input wire evt_hdr_t frm_hdr,
    input wire logic res_valid,
    input wire logic res_hit,
    input wire evt_hdr_t res_hdr
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_ack_one_cycle: assert property (tbl_ack == $past(tbl_wr)) else $error("ack late");
    a_res_one_cycle: assert property (res_valid == $past(frm_valid)) else $error("result late");
    a_err_with_ack: assert property (tbl_err |-> tbl_ack) else $error("lone err");
    a_err_keeps_count: assert property (tbl_err |-> $stable(tbl_count)) else $error("count moved");
    a_delete_shrinks: assert property (tbl_wr && &tbl_wdata[63:0] |=>
        tbl_err || tbl_count == $past(tbl_count) - 1) else $error("no delete");
    a_bytes_track: assert property (attr_sel == 3'h6 |=>
        attr_rdata == 16 * $past(tbl_count)) else $error("bytes");
    a_cap_value: assert property (attr_sel == 3'h2 |=> attr_rdata == N_ENT) else $error("capacity");
    a_miss_passes: assert property (res_valid && !res_hit |->
        res_hdr == $past(frm_hdr)) else $error("miss altered");
    c_refused: cover property (tbl_err);
    c_hit: cover property (res_valid && res_hit);
    c_pass: cover property (res_valid && !res_hit);
endmodule : evt_assertions

bind evt_tagger evt_assertions #(.N_ENT(N_ENT)) u_chk (.*);

//--- tb/evt_mgr_model.sv
// Purpose: line terminal manager model writing rule entries
// Assumes: clock from the bench
// Notes: between writes the bus shows the inverted last entry
module evt_mgr_model (
    // table write side
    input wire logic clk,
    input wire logic tbl_ack,
    output logic tbl_wr,
    output logic [127:0] tbl_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        tbl_wr = 1'b0;
        tbl_wdata = '0;
    end
    // a strobe held past one edge would be a second write
    task automatic put(input logic [127:0] d);
        @(negedge clk);
        tbl_wr = 1'b1;
        tbl_wdata = d;
        @(negedge clk);
        tbl_wr = 1'b0;
        tbl_wdata = ~d;
        for (int n = 0; n < 3 && tbl_ack !== 1'b1; n++) @(negedge clk);
    endtask : put
endmodule : evt_mgr_model

//--- tb/tb_evt_tagger.sv
// Purpose: self-checking bench of the rule tagger
// Assumes: capacity cut to four entries so one rule fills the table
// Notes: a watcher pops expected results from queues
`include "evt_defines.svh"
module tb_evt_tagger import evt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int N_ENT = 4;
    localparam logic [15:0] AX [8] = '{16'h0001, 16'h0000, 16'h0004, 16'h88A8, 16'h88A8, 16'h0000, 16'h0030, 16'h0000};
    localparam logic [127:0] DV [3] = '{`EVT_DFLT_DBL, `EVT_DFLT_SGL, `EVT_DFLT_UNT};
    logic clk = 1'b0, rst_n = 1'b0, attr_wr = 1'b0, frm_valid = 1'b0, frm_dir = 1'b0;
    logic tbl_wr, tbl_ack, tbl_err, res_valid, res_hit;
    logic [2:0] attr_sel = 3'h0, tbl_count;
    logic [15:0] attr_wdata = 16'h0000, attr_rdata;
    logic [1:0] tbl_rd_idx = 2'h0, res_idx;
    logic [127:0] tbl_wdata, tbl_rd_data;
    evt_hdr_t frm_hdr = '0, res_hdr, h, r;
    evt_entry_t e;
    logic qa[$];
    logic [52:0] qf[$];
    int bad_count = 0, num_checks = 0, cyc = 0;
    always #50 clk = ~clk;
    evt_tagger #(.N_ENT(N_ENT)) dut (.*);
    evt_mgr_model u_mgr (.*);
    task automatic results();
        if (qa.size() + qf.size() > 0) bad_count++;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // --------
    // watcher
    // --------
    always @(negedge clk) begin
        if (tbl_ack === 1'b1) chk(tbl_err, qa.pop_front());
        if (res_valid === 1'b1) chk({res_hit, res_hit ? res_idx : 2'h0, res_hdr.ntags, res_hdr.inner,
            res_hdr.etype}, qf.pop_front());
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            results();
        end
    end
    task automatic frm(input logic d, input evt_hdr_t x, input logic hit, input logic [1:0] i, input evt_hdr_t y);
        qf.push_back({hit, i, y.ntags, y.inner, y.etype});
        frm_dir = d;
        frm_hdr = x;
        frm_valid = 1'b1;
        @(negedge clk);
        frm_valid = 1'b0;
        frm_hdr = ~x;
        @(negedge clk);
    endtask : frm
    task automatic tw(input logic [127:0] d, input logic err);
        qa.push_back(err);
        u_mgr.put(d);
    endtask : tw
    task automatic aw(input logic [2:0] s, input logic [15:0] d);
        attr_sel = s;
        attr_wdata = d;
        attr_wr = 1'b1;
        @(negedge clk);
        attr_wr = 1'b0;
        @(negedge clk);
    endtask : aw
    task automatic ar(input logic [2:0] s, input logic [15:0] x);
        attr_sel = s;
        repeat (2) @(negedge clk);
        chk(attr_rdata, x);
    endtask : ar
    initial begin
        void'($urandom(32'hF044));
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 8; i++) ar(i[2:0], AX[i]);
        for (int i = 0; i < 3; i++) begin
            tbl_rd_idx = i[1:0];
            @(negedge clk);
            chk(tbl_rd_data, DV[i]);
        end
        aw(3'h3, 16'h9100);
        aw(3'h2, 16'h0000);
        ar(3'h3, 16'h9100);
        h = '0;
        h.etype = 16'($urandom());
        frm(1'b0, h, 1'b1, 2'h2, h);
        e = '0;
        e.fo_prio = 4'hF;
        e.fi_prio = 4'h8;
        e.fi_vid = 13'h0064;
        e.t_rm = 2'h1;
        e.to_prio = 4'hF;
        e.ti_prio = 4'h3;
        e.ti_vid = 13'h00C8;
        e.ti_tpid = 3'h4;
        tw(e, 1'b0);
        ar(3'h6, 16'h0040);
        tbl_rd_idx = 2'h1;
        @(negedge clk);
        chk(tbl_rd_data, e);
        h.ntags = 2'h1;
        h.inner = {16'h8100, 3'($urandom()), 1'b1, 12'h064};
        r = h;
        r.inner = {16'h88A8, 3'h3, 1'b1, 12'h0C8};
        frm(1'b0, h, 1'b1, 2'h1, r);
        frm(1'b1, r, 1'b1, 2'h1, {h[81:48], 16'h8100, 3'h0, 1'b0, 12'h064, h.etype});
        r = h;
        r.ntags = 2'h2;
        r.outer = h.inner;
        frm(1'b0, r, 1'b1, 2'h0, r);
        tw({4'h1, 60'($urandom()), 64'h0}, 1'b1);
        e.ti_vid = 13'h012C;
        tw(e, 1'b0);
        r = h;
        r.inner = {16'h88A8, 3'h3, 1'b1, 12'h12C};
        frm(1'b0, h, 1'b1, 2'h1, r);
        aw(3'h5, 16'h0001);
        ar(3'h5, 16'h0001);
        frm(1'b1, r, 1'b0, 2'h0, r);
        tw({e[127:64], `EVT_DEL_MARK}, 1'b0);
        tw({e[127:64], `EVT_DEL_MARK}, 1'b1);
        chk(tbl_count, 3'h3);
        frm(1'b0, h, 1'b1, 2'h1, h);
        repeat (2) @(negedge clk);
        results();
    end
endmodule : tb_evt_tagger
